// ### epc_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM slave with byte addresses, one word per register
// Notes:   definitions only
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH

// register byte offsets
`define EPC_OFS_CTRL      5'h00
`define EPC_OFS_LINES     5'h04
`define EPC_OFS_FILTER    5'h08
`define EPC_OFS_POSITION  5'h0C
`define EPC_OFS_CPS       5'h10
`define EPC_OFS_SHAFT_A   5'h14

// control field positions
`define EPC_CTRL_MODE_BIT 0
`define EPC_CTRL_SIGN_BIT 1

// reset values
`define EPC_CTRL_RST      2'h0
`define EPC_LINES_RST     16'h0400
`define EPC_FILTER_RST    4'h4

// line setting limits
`define EPC_LINES_MIN     16'h000A
`define EPC_LINES_MAX     16'h1388

// speed fraction bits and timing
`define EPC_FRAC_BITS     8
`define EPC_CLK_HZ        200000000
`define EPC_GATE_TIME_MS  1000

`endif

// ### epc_pkg.sv
// Purpose: shared types of the encoder pulse counter
// Assumes: constants live in epc_regs.svh
// Notes:   bus request and answer travel as packed structs
`default_nettype none
package epc_pkg;

    // counting mode selection
    typedef enum logic {
        EPC_MODE_PULSE = 1'b0,
        EPC_MODE_QUAD  = 1'b1
    } epc_mode_t;

    // divider and filter sequencing
    typedef enum logic [1:0] {
        EPC_DIV_IDLE = 2'b00,
        EPC_DIV_RUN  = 2'b01,
        EPC_DIV_FILT = 2'b10
    } epc_div_state_t;

    // avalon request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } epc_avs_req_t;

    // avalon answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } epc_avs_rsp_t;

endpackage
`default_nettype wire

// ### epc_sync.sv
// Purpose: two-stage synchroniser for pins outside the clock domain
// Assumes: inputs are asynchronous levels
// Notes:   the first stage feeds only the second stage
`default_nettype none
`timescale 1ns/1ps
module epc_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // two flops; metastability settles in the first
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // epc_sync
`default_nettype wire

// ### epc_counter.sv
// Purpose: encoder position counter and filtered shaft speed with Avalon-MM registers
// Assumes: 200 MHz sys_clk_in, encoder pins asynchronous to it
// Notes:   speed in hertz with 8 fraction bits, refreshed once per gate window
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`default_nettype none
`timescale 1ns/1ps
`include "epc_regs.svh"

module epc_counter #(
    parameter int GATE_CYCLES    = (`EPC_CLK_HZ / 1000) * `EPC_GATE_TIME_MS,
    parameter bit OPTION_CHANNEL = 1'b0
) (
    // clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    // encoder pins
    input  wire logic                  pulse_input_pin_in,
    input  wire logic                  direction_input_pin_in,
    // register bus
    input  wire epc_pkg::epc_avs_req_t avs_req_in,
    output epc_pkg::epc_avs_rsp_t      avs_rsp_out,
    // measurements
    output logic [31:0]                position_out,
    output logic [31:0]                shaft_a_out
);

    localparam logic [27:0] GATE_LAST = 28'(GATE_CYCLES - 1);

    logic [1:0]                    pins_sync;
    logic                          a_prev_reg;
    logic                          b_prev_reg;
    logic [1:0]                    ctrl_reg;
    logic [15:0]                   lines_reg;
    logic [3:0]                    filt_time_reg;
    logic [31:0]                   pos_reg;
    logic [31:0]                   win_reg;
    logic [31:0]                   cps_reg;
    logic [27:0]                   gate_reg;
    epc_pkg::epc_div_state_t       div_state_reg;
    logic [5:0]                    div_cnt_reg;
    logic [31:0]                   quo_reg;
    logic [15:0]                   rem_reg;
    logic                          neg_reg;
    logic [31:0]                   filt_reg;
    logic                          ack_reg;
    logic [31:0]                   rdata_reg;
    logic [1:0]                    prime_reg;

    // two-stage synchroniser on both pins
    epc_sync #(
        .WIDTH    (2)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({pulse_input_pin_in, direction_input_pin_in}),
        .sync_out   (pins_sync)
    );

    wire a_now = pins_sync[1];
    wire b_now = pins_sync[0];

    // edges count only once both sync stages and the prev flops hold real levels,
    // so a shaft parked with a phase high gives no false step after reset
    wire primed = (prime_reg == 2'h3);

    // mode; the option-card channel cannot run pulse counting
    wire epc_pkg::epc_mode_t mode = (OPTION_CHANNEL || ctrl_reg[`EPC_CTRL_MODE_BIT])
                                    ? epc_pkg::EPC_MODE_QUAD
                                    : epc_pkg::EPC_MODE_PULSE;
    wire invert = ctrl_reg[`EPC_CTRL_SIGN_BIT];

    // pulse/direction event decode
    wire rise_evt  = primed && a_now && !a_prev_reg;
    wire pulse_evt = (mode == epc_pkg::EPC_MODE_PULSE) && rise_evt;
    wire pulse_up  = b_now;

    // quadrature decode; a double change is a glitch and is dropped
    wire a_chg    = primed && (a_now ^ a_prev_reg);
    wire b_chg    = primed && (b_now ^ b_prev_reg);
    wire quad_evt = (mode == epc_pkg::EPC_MODE_QUAD) && (a_chg ^ b_chg);
    wire quad_up  = a_now ^ b_prev_reg;

    // one signed step per event, sign bit flips direction
    wire count_evt = pulse_evt || quad_evt;
    wire raw_up    = pulse_evt ? pulse_up : quad_up;
    wire step_up   = raw_up ^ invert;
    wire [31:0] step = step_up ? 32'h0000_0001 : 32'hFFFF_FFFF;

    // gate window closes once per second at the default gate
    wire gate_tick = (gate_reg == GATE_LAST);
    wire [31:0] win_evt = count_evt ? win_reg + step : win_reg;

    // position and per-window accumulator
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            prime_reg  <= 2'h0;
            pos_reg    <= 32'h0000_0000;
            win_reg    <= 32'h0000_0000;
            cps_reg    <= 32'h0000_0000;
            gate_reg   <= 28'h0000000;
        end else begin
            a_prev_reg <= a_now;
            b_prev_reg <= b_now;
            if (!primed) begin
                prime_reg <= prime_reg + 2'h1;
            end
            if (count_evt) begin
                pos_reg <= pos_reg + step;
            end
            gate_reg <= gate_tick ? 28'h0000000 : gate_reg + 28'h0000001;
            win_reg  <= gate_tick ? 32'h0000_0000 : win_evt;
            if (gate_tick) begin
                cps_reg <= win_evt;
            end
        end
    end

    // divisor is lines, or four times lines in quadrature
    wire [15:0] divisor = (mode == epc_pkg::EPC_MODE_QUAD) ? {lines_reg[13:0], 2'b00}
                                                           : lines_reg;
    // magnitude of the window count, fraction bits appended; limited to 2^24 counts
    wire [31:0] win_mag  = win_evt[31] ? 32'(-win_evt) : win_evt;
    wire [31:0] numer    = {win_mag[23:0], 8'h00};
    wire [15:0] rem_sh   = {rem_reg[14:0], quo_reg[31]};
    wire        sub_ok   = rem_sh >= divisor;
    wire [31:0] raw_spd  = neg_reg ? 32'(-quo_reg) : quo_reg;
    wire [31:0] filt_dif = raw_spd - filt_reg;
    wire [31:0] filt_inc = 32'($signed(filt_dif) >>> filt_time_reg);

    // restoring divider then first-order lag filter, one pass per window
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_state_reg <= epc_pkg::EPC_DIV_IDLE;
            div_cnt_reg   <= 6'h00;
            quo_reg       <= 32'h0000_0000;
            rem_reg       <= 16'h0000;
            neg_reg       <= 1'b0;
            filt_reg      <= 32'h0000_0000;
        end else begin
            unique case (div_state_reg)
                epc_pkg::EPC_DIV_IDLE: begin
                    if (gate_tick) begin
                        quo_reg       <= numer;
                        rem_reg       <= 16'h0000;
                        neg_reg       <= win_evt[31];
                        div_cnt_reg   <= 6'h00;
                        div_state_reg <= epc_pkg::EPC_DIV_RUN;
                    end
                end
                epc_pkg::EPC_DIV_RUN: begin
                    rem_reg     <= sub_ok ? rem_sh - divisor : rem_sh;
                    quo_reg     <= {quo_reg[30:0], sub_ok};
                    div_cnt_reg <= div_cnt_reg + 6'h01;
                    if (div_cnt_reg == 6'h1F) begin
                        div_state_reg <= epc_pkg::EPC_DIV_FILT;
                    end
                end
                epc_pkg::EPC_DIV_FILT: begin
                    filt_reg      <= filt_reg + filt_inc;
                    div_state_reg <= epc_pkg::EPC_DIV_IDLE;
                end
                default: begin
                    div_state_reg <= epc_pkg::EPC_DIV_IDLE;
                end
            endcase
        end
    end

    // bus decode; one wait cycle on every access
    wire        acc      = avs_req_in.read || avs_req_in.write;
    wire        wait_req = acc && !ack_reg;
    wire        wr_take  = avs_req_in.write && ack_reg;
    wire [4:0]  addr     = avs_req_in.address;
    wire [31:0] be_mask  = {{8{avs_req_in.byteenable[3]}}, {8{avs_req_in.byteenable[2]}},
                            {8{avs_req_in.byteenable[1]}}, {8{avs_req_in.byteenable[0]}}};
    wire [31:0] wdata    = avs_req_in.writedata & be_mask;
    wire        wr_ctrl  = wr_take && (addr == `EPC_OFS_CTRL);
    wire        wr_lines = wr_take && (addr == `EPC_OFS_LINES);
    wire        wr_filt  = wr_take && (addr == `EPC_OFS_FILTER);

    // merged and clamped line setting
    wire [15:0] lines_m = (lines_reg & ~be_mask[15:0]) | wdata[15:0];
    wire [15:0] lines_c = (lines_m < `EPC_LINES_MIN) ? `EPC_LINES_MIN :
                          (lines_m > `EPC_LINES_MAX) ? `EPC_LINES_MAX : lines_m;
    wire [1:0]  ctrl_m  = (ctrl_reg & ~be_mask[1:0]) | wdata[1:0];
    wire [3:0]  filt_m  = (filt_time_reg & ~be_mask[3:0]) | wdata[3:0];

    // read selection; unmapped addresses read zero
    wire [31:0] rd_sel =
        (addr == `EPC_OFS_CTRL)     ? {30'h0, ctrl_reg}        :
        (addr == `EPC_OFS_LINES)    ? {16'h0000, lines_reg}    :
        (addr == `EPC_OFS_FILTER)   ? {28'h0000000, filt_time_reg} :
        (addr == `EPC_OFS_POSITION) ? pos_reg                  :
        (addr == `EPC_OFS_CPS)      ? cps_reg                  :
        (addr == `EPC_OFS_SHAFT_A)  ? filt_reg                 : 32'h0000_0000;

    // registers and answer timing
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            ctrl_reg      <= `EPC_CTRL_RST;
            lines_reg     <= `EPC_LINES_RST;
            filt_time_reg <= `EPC_FILTER_RST;
        end else begin
            ack_reg <= wait_req;
            if (avs_req_in.read && !ack_reg) begin
                rdata_reg <= rd_sel;
            end
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_m;
            end
            if (wr_lines) begin
                lines_reg <= lines_c;
            end
            if (wr_filt) begin
                filt_time_reg <= filt_m;
            end
        end
    end

    // outputs
    assign avs_rsp_out.readdata    = rdata_reg;
    assign avs_rsp_out.waitrequest = wait_req;
    assign position_out            = pos_reg;
    assign shaft_a_out             = filt_reg;

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_pulse_up_count: assert property (
        pulse_evt && b_now && !invert |=> pos_reg == $past(pos_reg) + 32'h1)
        else $error("pulse with direction high did not count up");
    chk_pulse_down_count: assert property (
        pulse_evt && !b_now && !invert |=> pos_reg == $past(pos_reg) - 32'h1)
        else $error("pulse with direction low did not count down");
    chk_pulse_edge_only: assert property (
        mode == epc_pkg::EPC_MODE_PULSE && !rise_evt |=> pos_reg == $past(pos_reg))
        else $error("pulse mode counted without a rising edge");
    chk_quad_dir_up: assert property (
        quad_evt && (a_now ^ b_prev_reg) && !invert |=> pos_reg == $past(pos_reg) + 32'h1)
        else $error("quadrature forward step did not count up");
    chk_quad_every_edge: assert property (
        mode == epc_pkg::EPC_MODE_QUAD && (a_chg ^ b_chg) |=> pos_reg != $past(pos_reg))
        else $error("quadrature edge was not counted");
    chk_sign_invert: assert property (
        pulse_evt && b_now && invert |=> pos_reg == $past(pos_reg) - 32'h1)
        else $error("sign inversion not applied");
    chk_sync_two_flop: assert property (
        rise_evt |-> $past(pulse_input_pin_in, 2) && !$past(pulse_input_pin_in, 3))
        else $error("edge seen without two-flop delay");
    chk_lines_range: assert property (
        lines_reg >= `EPC_LINES_MIN && lines_reg <= `EPC_LINES_MAX)
        else $error("line setting outside range");
    chk_option_quad: assert property (
        OPTION_CHANNEL |-> mode == epc_pkg::EPC_MODE_QUAD)
        else $error("option channel left quadrature mode");
    chk_speed_update: assert property (
        gate_tick |-> ##34 div_state_reg == epc_pkg::EPC_DIV_IDLE)
        else $error("speed update did not finish in 34 cycles");
    chk_reset_clear: assert property (
        !$past(rst_n_in) |-> pos_reg == 32'h0 && filt_reg == 32'h0 && win_reg == 32'h0)
        else $error("state not cleared after reset");

    // direction, settling and speed path checks
    chk_prime_block: assert property (
        !primed |=> pos_reg == $past(pos_reg))
        else $error("count moved before the synchroniser filled");
    chk_quad_dir_down: assert property (
        quad_evt && !(a_now ^ b_prev_reg) && !invert |=> pos_reg == $past(pos_reg) - 32'h1)
        else $error("quadrature reverse step did not count down");
    chk_sign_quad: assert property (
        quad_evt && (a_now ^ b_prev_reg) && invert |=> pos_reg == $past(pos_reg) - 32'h1)
        else $error("sign inversion not applied in quadrature");
    chk_cps_snapshot: assert property (
        gate_tick |=> cps_reg == $past(win_evt))
        else $error("window count not captured at gate end");
    chk_filter_pass: assert property (
        div_state_reg == epc_pkg::EPC_DIV_FILT && filt_time_reg == 4'h0
        |=> filt_reg == $past(raw_spd))
        else $error("unfiltered speed not passed through");

endmodule // epc_counter
`default_nettype wire

// ### epc_enc_model.sv
// Purpose: encoder and pulse/direction source standing at the counter's pins
// Assumes: link rate 125 ns per step, 25 periods of the 200 MHz clock, so fixed in phase to the system clock
// Notes:   each level holds 62.5 ns or more, far above the counter's 3 cycles
`default_nettype none
`timescale 1ns/1ps
module epc_enc_model (
    // pins toward the counter
    output logic pin_a_out,
    output logic pin_b_out
);
    localparam realtime HALF = 62.5;
    // callers start just after a clock edge; the skew keeps pin changes off edges
    localparam realtime SKEW = 1.3;

    // both pins idle low
    initial begin
        pin_a_out = 1'b0;
        pin_b_out = 1'b0;
    end

    // direction settles before the first rise, each pulse ends low
    task automatic pulses(input logic up, input int n);
        #SKEW;
        pin_b_out = up;
        repeat (n) begin
            #HALF pin_a_out = 1'b1;
            #HALF pin_a_out = 1'b0;
        end
    endtask

    // one phase changes per step, a leads b when counting up
    task automatic quad(input logic up, input int n);
        #SKEW;
        repeat (n) begin
            #(2 * HALF);
            if ((pin_a_out == pin_b_out) == up) begin
                pin_a_out = ~pin_a_out;
            end else begin
                pin_b_out = ~pin_b_out;
            end
        end
    endtask
endmodule // epc_enc_model
`default_nettype wire

// ### tb_encoder_pulse_counter.sv
// Purpose: self-checking bench for the encoder pulse counter
// Assumes: gate window shortened to 1000 cycles, so 40 steps land per window
// Notes:   speed runs use the minimum line setting and no filtering
`default_nettype none
`timescale 1ns/1ps
`include "epc_regs.svh"
module tb_encoder_pulse_counter;
    logic                  sys_clk_in = 1'b0;
    logic                  rst_n_in   = 1'b0;
    wire logic             pin_a;
    wire logic             pin_b;
    epc_pkg::epc_avs_req_t req        = '0;
    epc_pkg::epc_avs_rsp_t rsp;
    logic [31:0]           pos;
    logic [31:0]           spd;
    logic [31:0]           pos_opt;
    logic [31:0]           rd;
    int                    n_mismatch = 0;
    int                    checks     = 0;

    // 200 MHz clock
    always #2.5 sys_clk_in = ~sys_clk_in;

    epc_counter #(.GATE_CYCLES(1000), .OPTION_CHANNEL(1'b0)) DUT (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pulse_input_pin_in(pin_a), .direction_input_pin_in(pin_b),
        .avs_req_in(req), .avs_rsp_out(rsp),
        .position_out(pos), .shaft_a_out(spd));

    // option-card channel on the same pins and bus, forced to quadrature
    epc_counter #(.GATE_CYCLES(1000), .OPTION_CHANNEL(1'b1)) DUT_OPT (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pulse_input_pin_in(pin_a), .direction_input_pin_in(pin_b),
        .avs_req_in(req), .avs_rsp_out(),
        .position_out(pos_opt), .shaft_a_out());

    epc_enc_model ENC (.pin_a_out(pin_a), .pin_b_out(pin_b));

    // one comparison of a 32-bit result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until the edge that sees waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        @(posedge sys_clk_in);
        req <= '{read: ~wr, write: wr, address: a, writedata: wd, byteenable: 4'hF};
        do begin
            @(posedge sys_clk_in);
        end while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req <= '0;
    endtask

    // register read and compare
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // step the source, then compare the position change on pins and bus
    task automatic move(input logic q, input logic up, input int n, input logic [31:0] d);
        logic [31:0] p0;
        p0 = pos;
        if (q) begin
            ENC.quad(up, n);
        end else begin
            ENC.pulses(up, n);
        end
        repeat (10) @(posedge sys_clk_in);
        chk(pos, p0 + d);
        rd_chk(`EPC_OFS_POSITION, p0 + d);
    endtask

    // reset contents, unmapped place reads zero
    task automatic t_reset_values;
        rd_chk(`EPC_OFS_CTRL, 32'h00000000);
        rd_chk(`EPC_OFS_LINES, 32'(`EPC_LINES_RST));
        rd_chk(`EPC_OFS_FILTER, 32'(`EPC_FILTER_RST));
        rd_chk(`EPC_OFS_POSITION, 32'h00000000);
        rd_chk(`EPC_OFS_CPS, 32'h00000000);
        rd_chk(`EPC_OFS_SHAFT_A, 32'h00000000);
        rd_chk(5'h18, 32'h00000000);
    endtask

    // line setting held at its limits, ends at the minimum
    task automatic t_clamp;
        bus(1'b1, `EPC_OFS_LINES, 32'h00000003);
        rd_chk(`EPC_OFS_LINES, 32'h0000000A);
        bus(1'b1, `EPC_OFS_LINES, 32'h00001770);
        rd_chk(`EPC_OFS_LINES, 32'h00001388);
        bus(1'b1, `EPC_OFS_LINES, 32'h0000000A);
        rd_chk(`EPC_OFS_LINES, 32'h0000000A);
    endtask

    // pulse mode asked for: main channel counts one rise of a as a down step, option channel four
    task automatic t_option;
        logic [31:0] p0;
        logic [31:0] q0;
        bus(1'b1, `EPC_OFS_CTRL, 32'h00000000);
        p0 = pos;
        q0 = pos_opt;
        ENC.quad(1'b1, 4);
        repeat (10) @(posedge sys_clk_in);
        chk(pos_opt, q0 + 32'h00000004);
        chk(pos, p0 - 32'h00000001);
    endtask

    // counting in both modes and both directions, then inverted
    task automatic t_counting;
        bus(1'b1, `EPC_OFS_CTRL, 32'h00000000);
        move(1'b0, 1'b1, 5, 32'h00000005);
        move(1'b0, 1'b0, 3, 32'hFFFFFFFD);
        bus(1'b1, `EPC_OFS_CTRL, 32'h00000001);
        move(1'b1, 1'b1, 8, 32'h00000008);
        move(1'b1, 1'b0, 8, 32'hFFFFFFF8);
        bus(1'b1, `EPC_OFS_CTRL, 32'h00000003);
        move(1'b1, 1'b1, 4, 32'hFFFFFFFC);
    endtask

    // steady source, speed read after several full windows
    task automatic t_speed(input logic [31:0] ctrl, input logic [31:0] exp);
        bus(1'b1, `EPC_OFS_CTRL, ctrl);
        bus(1'b1, `EPC_OFS_FILTER, 32'h00000000);
        fork
            if (ctrl[0]) ENC.quad(1'b1, 240);
            else ENC.pulses(1'b1, 240);
            begin
                repeat (4500) @(posedge sys_clk_in);
                chk(spd, exp);
                rd_chk(`EPC_OFS_SHAFT_A, exp);
            end
        join
    endtask

    // second reset while the shaft turns clears the measurements
    task automatic t_reset_mid;
        fork
            ENC.quad(1'b1, 80);
            begin
                repeat (1500) @(posedge sys_clk_in);
                rst_n_in <= 1'b0;
                repeat (3) @(posedge sys_clk_in);
                chk(pos, 32'h00000000);
                chk(spd, 32'h00000000);
                rst_n_in <= 1'b1;
            end
        join
        rd_chk(`EPC_OFS_CTRL, 32'h00000000);
    endtask

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset_values;
        t_clamp;
        t_option;
        t_counting;
        t_speed(32'h00000000, 32'h00000400);
        t_speed(32'h00000001, 32'h00000100);
        t_speed(32'h00000003, 32'hFFFFFF00);
        t_reset_mid;
        stop_test;
    end

    // watchdog, about four times the expected run
    initial begin
        #400000;
        n_mismatch++;
        stop_test;
    end
endmodule // tb_encoder_pulse_counter
`default_nettype wire
